// *** rtl/crbt_pkg.sv ***
// Constants, types and register map shared by the capture/reload/baud timer
package crbt_pkg;

  // ************************************************************
  // Register addresses on the special-function register port
  // ************************************************************
  localparam logic [7:0] CRBT_ADDR_CTRL = 8'hc8;
  localparam logic [7:0] CRBT_ADDR_CAP_LO = 8'hca;
  localparam logic [7:0] CRBT_ADDR_CAP_HI = 8'hcb;
  localparam logic [7:0] CRBT_ADDR_CNT_LO = 8'hcc;
  localparam logic [7:0] CRBT_ADDR_CNT_HI = 8'hcd;

  // ************************************************************
  // Field positions of timer_control
  // ************************************************************
  localparam int CRBT_OVF_FLAG_BIT = 7;
  localparam int CRBT_EXT_FLAG_BIT = 6;
  localparam int CRBT_RX_BAUD_BIT = 5;
  localparam int CRBT_TX_BAUD_BIT = 4;
  localparam int CRBT_TRIG_EN_BIT = 3;
  localparam int CRBT_RUN_BIT = 2;
  localparam int CRBT_SRC_BIT = 1;
  localparam int CRBT_CAPSEL_BIT = 0;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0] CRBT_CTRL_RESET = 8'h00;
  localparam logic [15:0] CRBT_CAP_RESET = 16'h0000;
  localparam logic [15:0] CRBT_CNT_RESET = 16'h0000;
  localparam logic [15:0] CRBT_CNT_MAX = 16'hffff;
  localparam logic [15:0] CRBT_CNT_WRAP = 16'h0000;
  localparam logic [3:0] CRBT_PRESCALE_LAST = 4'hb;
  localparam int CRBT_PIN_COUNT = 2;
  localparam int CRBT_PIN_COUNT_IDX = 0;
  localparam int CRBT_PIN_TRIG_IDX = 1;

  // ************************************************************
  // Modes and state records
  // ************************************************************
  typedef enum logic [1:0] {
    CRBT_MODE_OFF,
    CRBT_MODE_CAPTURE,
    CRBT_MODE_RELOAD,
    CRBT_MODE_BAUD
  } crbt_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] cap;
    logic [15:0] cnt;
    logic [7:0] rdata;
    logic irq;
    logic rx_clk;
    logic tx_clk;
    logic conv_start;
  } crbt_state_t;

  typedef struct packed {
    logic [CRBT_PIN_COUNT-1:0] meta;
    logic [CRBT_PIN_COUNT-1:0] sync;
    logic [CRBT_PIN_COUNT-1:0] prev;
    logic [CRBT_PIN_COUNT-1:0] fall;
  } crbt_sync_state_t;

  typedef struct packed {
    logic [3:0] div;
    logic half;
    logic div_tick;
    logic half_tick;
  } crbt_tick_state_t;

endpackage : crbt_pkg

// *** rtl/crbt_evt_if.sv ***
// Interface carrying internal timebase and pin events to the timer core
`timescale 1ns/10ps
interface crbt_evt_if;
  logic count_fall;
  logic trig_fall;
  logic div12_tick;
  logic half_tick;

  modport pin_src (output count_fall, output trig_fall);
  modport tick_src (output div12_tick, output half_tick);
  modport sink (input count_fall, input trig_fall, input div12_tick, input half_tick);
endinterface : crbt_evt_if

// *** rtl/crbt_edge_sync.sv ***
// Pin synchroniser and falling-edge detector for the count and trigger pins
`timescale 1ns/10ps
module crbt_edge_sync
  import crbt_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic external_count_pin_in,
  input wire logic external_trigger_pin_in,
  crbt_evt_if.pin_src evt
);

  crbt_sync_state_t s_q;
  crbt_sync_state_t s_d;
  logic [CRBT_PIN_COUNT-1:0] pins;

  assign pins[CRBT_PIN_COUNT_IDX] = external_count_pin_in;
  assign pins[CRBT_PIN_TRIG_IDX] = external_trigger_pin_in;

  // ************************************************************
  // Two flops, then an edge stage that sees only the second flop
  // ************************************************************
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < CRBT_PIN_COUNT; i++) begin
      s_d.meta[i] = pins[i];
      s_d.sync[i] = s_q.meta[i];
      s_d.prev[i] = s_q.sync[i];
      s_d.fall[i] = s_q.prev[i] & ~s_q.sync[i]; // [RULE20]
    end
  end

  // Idle level high, so a pin low at release reads as one falling edge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{meta: '1, sync: '1, prev: '1, fall: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.count_fall = s_q.fall[CRBT_PIN_COUNT_IDX];
  assign evt.trig_fall = s_q.fall[CRBT_PIN_TRIG_IDX];

endmodule : crbt_edge_sync

// *** rtl/crbt_tick_gen.sv ***
// Free-running divide-by-12 and divide-by-2 timebase ticks
`timescale 1ns/10ps
module crbt_tick_gen
  import crbt_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  crbt_evt_if.tick_src evt
);

  crbt_tick_state_t s_q;
  crbt_tick_state_t s_d;

  // ************************************************************
  // Dividers
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.div = (s_q.div == CRBT_PRESCALE_LAST) ? 4'h0 : 4'(s_q.div + 4'h1);
    s_d.div_tick = (s_q.div == CRBT_PRESCALE_LAST); // [RULE2]
    s_d.half = ~s_q.half;
    s_d.half_tick = s_q.half; // [RULE13]
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.div12_tick = s_q.div_tick;
  assign evt.half_tick = s_q.half_tick;

endmodule : crbt_tick_gen

// *** rtl/crbt_timer.sv ***
// Top of the 16-bit capture / auto-reload / baud-rate timer
// Operation
// (RULE1) One 16-bit up-counter, readable and writable as low and high bytes.
// (RULE2) Source clear: count core clock, undivided or divided by 12 by prescale_select.
// (RULE3) Source set: count once per falling edge on the external count pin.
// (RULE4) Run bit 1 starts counting; run bit 0 turns timer off in every mode.
// (RULE5) Capture mode when capture select and run set, both baud selects clear.
// (RULE6) Capture mode trigger edge copies count to capture pair, sets trigger flag.
// (RULE7) Trigger enable clear: trigger pin edges do nothing at all.
// (RULE8) Capture and reload modes: wrap from all ones sets overflow flag.
// (RULE9) Reload mode: each overflow loads the capture pair into the counter.
// (RULE10) Reload mode trigger edge also reloads counter and sets trigger flag.
// (RULE11) Either baud select puts timer in baud mode, always reloading.
// (RULE12) Baud mode: no overflow flag; overflows go to serial shift clocks.
// (RULE13) Baud mode with internal source advances at half core clock rate.
// (RULE14) Baud mode with pin source advances on count pin falling edges.
// (RULE15) Each baud select picks this or the other timer for its serial clock.
// (RULE16) Baud mode trigger edge only sets trigger flag, an extra interrupt.
// (RULE17) Flags cleared only by software; either flag plus enable requests interrupt.
// (RULE18) Capture pair takes captures, supplies reloads, and is software accessible.
// (RULE19) Timer provides a conversion-start event for the converter.
// (RULE20) Count and trigger pins synchronised; falling edges become one-cycle pulses.
// (RULE21) Conversion start is a one-cycle pulse on every overflow while running.
`timescale 1ns/10ps
module crbt_timer
  import crbt_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic prescale_select_in,
  input wire logic int_enable_in,
  input wire logic other_timer_overflow_in,
  input wire logic external_count_pin_in,
  input wire logic external_trigger_pin_in,
  output logic timer_irq_out,
  output logic rx_baud_clk_out,
  output logic tx_baud_clk_out,
  output logic conv_start_out
);

  // ************************************************************
  // State and internal events
  // ************************************************************
  crbt_state_t s_q;
  crbt_state_t s_d;
  crbt_mode_t mode;
  crbt_evt_if evt ();

  logic run;
  logic baud;
  logic src_pin;
  logic trig_en;
  logic tick;
  logic at_max;
  logic ovf_evt;
  logic trig_evt;
  logic ovf_set;
  logic wr_ctrl;
  logic wr_cap_lo;
  logic wr_cap_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic [7:0] rd_mux;

  // ************************************************************
  // Helpers
  // ************************************************************
  crbt_edge_sync u_edge_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .external_count_pin_in(external_count_pin_in),
    .external_trigger_pin_in(external_trigger_pin_in),
    .evt(evt.pin_src)
  );

  crbt_tick_gen u_tick_gen (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .evt(evt.tick_src)
  );

  // ************************************************************
  // Mode decode
  // ************************************************************
  assign run = s_q.ctrl[CRBT_RUN_BIT];
  assign baud = s_q.ctrl[CRBT_RX_BAUD_BIT] | s_q.ctrl[CRBT_TX_BAUD_BIT]; // [RULE11]
  assign src_pin = s_q.ctrl[CRBT_SRC_BIT];
  assign trig_en = s_q.ctrl[CRBT_TRIG_EN_BIT];

  always_comb begin
    if (!run) begin
      mode = CRBT_MODE_OFF; // [RULE4]
    end else if (baud) begin
      mode = CRBT_MODE_BAUD; // [RULE11]
    end else if (s_q.ctrl[CRBT_CAPSEL_BIT]) begin
      mode = CRBT_MODE_CAPTURE; // [RULE5]
    end else begin
      mode = CRBT_MODE_RELOAD; // [RULE5]
    end
  end

  // ************************************************************
  // Count source
  // ************************************************************
  // Baud mode ignores the prescaler: fixed half-rate timebase unless the pin source is selected
  always_comb begin
    if (src_pin) begin
      tick = evt.count_fall; // [RULE3] [RULE14]
    end else if (baud) begin
      tick = evt.half_tick; // [RULE13]
    end else if (prescale_select_in) begin
      tick = 1'b1; // [RULE2]
    end else begin
      tick = evt.div12_tick; // [RULE2]
    end
  end

  assign at_max = (s_q.cnt == CRBT_CNT_MAX);
  assign ovf_evt = run & tick & at_max; // [RULE8] [RULE21]
  assign trig_evt = run & trig_en & evt.trig_fall; // [RULE7]
  assign ovf_set = ovf_evt & ~baud; // [RULE12]

  // ************************************************************
  // Register port decode
  // ************************************************************
  assign wr_ctrl = sfr_wr_in & (sfr_addr_in == CRBT_ADDR_CTRL);
  assign wr_cap_lo = sfr_wr_in & (sfr_addr_in == CRBT_ADDR_CAP_LO);
  assign wr_cap_hi = sfr_wr_in & (sfr_addr_in == CRBT_ADDR_CAP_HI);
  assign wr_cnt_lo = sfr_wr_in & (sfr_addr_in == CRBT_ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_wr_in & (sfr_addr_in == CRBT_ADDR_CNT_HI);

  always_comb begin
    case (sfr_addr_in)
      CRBT_ADDR_CTRL: rd_mux = s_q.ctrl;
      CRBT_ADDR_CAP_LO: rd_mux = s_q.cap[7:0]; // [RULE18]
      CRBT_ADDR_CAP_HI: rd_mux = s_q.cap[15:8]; // [RULE18]
      CRBT_ADDR_CNT_LO: rd_mux = s_q.cnt[7:0]; // [RULE1]
      CRBT_ADDR_CNT_HI: rd_mux = s_q.cnt[15:8]; // [RULE1]
      default: rd_mux = 8'h00;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;

    // Control: software write, then hardware sets win over clears
    if (wr_ctrl) begin
      s_d.ctrl = sfr_wdata_in;
    end
    if (ovf_set) begin
      s_d.ctrl[CRBT_OVF_FLAG_BIT] = 1'b1; // [RULE8] [RULE17]
    end
    if (trig_evt) begin
      s_d.ctrl[CRBT_EXT_FLAG_BIT] = 1'b1; // [RULE6] [RULE10] [RULE16] [RULE17]
    end

    // Capture pair: a capture beats a same-cycle software write
    if (wr_cap_lo) begin
      s_d.cap[7:0] = sfr_wdata_in; // [RULE18]
    end
    if (wr_cap_hi) begin
      s_d.cap[15:8] = sfr_wdata_in; // [RULE18]
    end
    if (mode == CRBT_MODE_CAPTURE && trig_evt) begin
      s_d.cap = s_q.cnt; // [RULE6]
    end

    // Counter: software write takes the cycle, no increment then
    if (wr_cnt_lo || wr_cnt_hi) begin
      if (wr_cnt_lo) begin
        s_d.cnt[7:0] = sfr_wdata_in; // [RULE1]
      end
      if (wr_cnt_hi) begin
        s_d.cnt[15:8] = sfr_wdata_in; // [RULE1]
      end
    end else begin
      unique case (mode)
        CRBT_MODE_OFF: begin
          s_d.cnt = s_q.cnt; // [RULE4]
        end
        CRBT_MODE_CAPTURE: begin
          if (tick) begin
            s_d.cnt = at_max ? CRBT_CNT_WRAP : 16'(s_q.cnt + 16'h0001); // [RULE8]
          end
        end
        CRBT_MODE_RELOAD: begin
          if (trig_evt) begin
            s_d.cnt = s_q.cap; // [RULE10]
          end else if (tick) begin
            s_d.cnt = at_max ? s_q.cap : 16'(s_q.cnt + 16'h0001); // [RULE9]
          end
        end
        CRBT_MODE_BAUD: begin
          if (tick) begin
            s_d.cnt = at_max ? s_q.cap : 16'(s_q.cnt + 16'h0001); // [RULE11] [RULE18]
          end
        end
      endcase
    end

    // Outputs, each one flop from its cause
    s_d.rdata = sfr_rd_in ? rd_mux : 8'h00;
    s_d.irq = int_enable_in & (s_d.ctrl[CRBT_OVF_FLAG_BIT] | s_d.ctrl[CRBT_EXT_FLAG_BIT]); // [RULE17]
    s_d.rx_clk = s_q.ctrl[CRBT_RX_BAUD_BIT] ? ovf_evt : other_timer_overflow_in; // [RULE12] [RULE15]
    s_d.tx_clk = s_q.ctrl[CRBT_TX_BAUD_BIT] ? ovf_evt : other_timer_overflow_in; // [RULE12] [RULE15]
    s_d.conv_start = ovf_evt; // [RULE19] [RULE21]
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{ctrl: CRBT_CTRL_RESET, cap: CRBT_CAP_RESET, cnt: CRBT_CNT_RESET,
               rdata: 8'h00, irq: 1'b0, rx_clk: 1'b0, tx_clk: 1'b0, conv_start: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata_out = s_q.rdata;
  assign timer_irq_out = s_q.irq;
  assign rx_baud_clk_out = s_q.rx_clk;
  assign tx_baud_clk_out = s_q.tx_clk;
  assign conv_start_out = s_q.conv_start;

endmodule : crbt_timer

// *** tb/crbt_timer_properties.sv ***
// Port-level assertions for the capture/reload/baud timer
`timescale 1ns/10ps
module crbt_timer_props
  import crbt_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic prescale_select_in,
  input wire logic int_enable_in,
  input wire logic other_timer_overflow_in,
  input wire logic external_count_pin_in,
  input wire logic external_trigger_pin_in,
  input wire logic timer_irq_out,
  input wire logic rx_baud_clk_out,
  input wire logic tx_baud_clk_out,
  input wire logic conv_start_out
);
  // ********
  // Checks
  // ********
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Flags written as ones, so a late hardware set cannot spoil it
  sequence s_ctrl_wr;
    sfr_wr_in && sfr_addr_in == CRBT_ADDR_CTRL && sfr_wdata_in[7:6] == 2'b11 && !sfr_wdata_in[CRBT_RUN_BIT];
  endsequence
  sequence s_ctrl_rd;
    sfr_rd_in && !sfr_wr_in && sfr_addr_in == CRBT_ADDR_CTRL;
  endsequence
  ctrl_readback_a: assert property (
    s_ctrl_wr ##1 s_ctrl_rd |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
    else $error("control readback wrong");
  unmapped_read_a: assert property (
    $past(sfr_rd_in) && !($past(sfr_addr_in) inside {8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd}) |-> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  irq_rise_a: assert property (
    $rose(timer_irq_out) |-> $past(int_enable_in))
    else $error("interrupt rose while disabled");
  irq_hold_a: assert property (
    $fell(timer_irq_out) |-> !$past(int_enable_in) || $past(sfr_wr_in))
    else $error("interrupt dropped without software");
  irq_gate_a: assert property (
    !$past(int_enable_in) |-> !timer_irq_out)
    else $error("interrupt while disabled");
  rx_source_a: assert property (
    rx_baud_clk_out |-> $past(other_timer_overflow_in) || conv_start_out)
    else $error("receive clock without source");
  tx_source_a: assert property (
    tx_baud_clk_out |-> $past(other_timer_overflow_in) || conv_start_out)
    else $error("transmit clock without source");
  ovf_irq_a: assert property (
    conv_start_out && !rx_baud_clk_out && !tx_baud_clk_out && $past(int_enable_in) |-> timer_irq_out)
    else $error("overflow gave no interrupt");
endmodule : crbt_timer_props

bind crbt_timer crbt_timer_props u_crbt_timer_props (
  .clock_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
  .prescale_select_in, .int_enable_in, .other_timer_overflow_in, .external_count_pin_in,
  .external_trigger_pin_in, .timer_irq_out, .rx_baud_clk_out, .tx_baud_clk_out, .conv_start_out
);

// *** tb/crbt_far_model.sv ***
// Far side: count and trigger pins, other timer, serial clock sink
`timescale 1ns/10ps
module crbt_far_model (
  input wire logic clock_in,
  input wire logic rx_clk_in,
  input wire logic tx_clk_in,
  output logic count_pin_out,
  output logic trig_pin_out,
  output logic other_ovf_out
);
  // ********
  // Model
  // ********
  int rx_seen = 0;
  int tx_seen = 0;
  // Pins idle high, as with a pull-up
  initial begin
    count_pin_out = 1'b1;
    trig_pin_out = 1'b1;
    other_ovf_out = 1'b0;
  end
  always @(posedge clock_in) begin
    rx_seen <= rx_seen + (rx_clk_in === 1'b1 ? 1 : 0);
    tx_seen <= tx_seen + (tx_clk_in === 1'b1 ? 1 : 0);
  end
  // Three cycles each level, past the two-cycle minimum
  task automatic fall(input bit trig);
    if (trig) begin
      trig_pin_out = 1'b0;
    end else begin
      count_pin_out = 1'b0;
    end
    repeat (3) @(posedge clock_in);
    #1;
    trig_pin_out = 1'b1;
    count_pin_out = 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
  endtask : fall
  task automatic other();
    other_ovf_out = 1'b1;
    @(posedge clock_in);
    #1;
    other_ovf_out = 1'b0;
  endtask : other
endmodule : crbt_far_model

// *** tb/crbt_timer_tb.sv ***
// Self-checking bench for the capture/reload/baud timer
`timescale 1ns/10ps
module crbt_timer_tb
  import crbt_pkg::*;
;
  typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] want;} crbt_row_t;
  crbt_row_t rows [6] = '{{8'hca, 8'h5a, 8'h5a}, {8'hcb, 8'ha5, 8'ha5}, {8'hcc, 8'h3c, 8'h3c},
    {8'hcd, 8'hc3, 8'hc3}, {8'hc9, 8'hff, 8'h00}, {8'hc8, 8'hc8, 8'hc8}};
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic prescale_select_in = 1'b1;
  logic int_enable_in = 1'b0;
  logic [7:0] sfr_rdata_out;
  logic other_timer_overflow_in, external_count_pin_in, external_trigger_pin_in;
  logic timer_irq_out, rx_baud_clk_out, tx_baud_clk_out, conv_start_out;
  logic [2:0] pulses;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int n, r0, t0;
  assign pulses = {tx_baud_clk_out, rx_baud_clk_out, conv_start_out};
  always #2 clock_in = ~clock_in;
  crbt_far_model u_crbt_far_model (.clock_in, .rx_clk_in(rx_baud_clk_out), .tx_clk_in(tx_baud_clk_out),
    .count_pin_out(external_count_pin_in), .trig_pin_out(external_trigger_pin_in),
    .other_ovf_out(other_timer_overflow_in));
  crbt_timer u_crbt_timer (.clock_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
    .sfr_rdata_out, .prescale_select_in, .int_enable_in, .other_timer_overflow_in, .external_count_pin_in,
    .external_trigger_pin_in, .timer_irq_out, .rx_baud_clk_out, .tx_baud_clk_out, .conv_start_out);
  // ********
  // Tasks
  // ********
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask : chk
  // Strobe stays up, so transfers run back to back
  task automatic txn(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_wr_in = w;
    sfr_rd_in = !w;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    @(posedge clock_in);
    #1;
  endtask : txn
  task automatic idle();
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    @(posedge clock_in);
    #1;
  endtask : idle
  task automatic wait_pulse(input int i);
    n = 0;
    while (pulses[i] !== 1'b1 && n < 100) begin
      @(posedge clock_in);
      #1;
      n++;
    end
  endtask : wait_pulse
  task automatic gap(input int i);
    wait_pulse(i);
    @(posedge clock_in);
    #1;
    wait_pulse(i);
    n++;
  endtask : gap
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    repeat (10) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    chk({4'h0, pulses, timer_irq_out}, 8'h00);
    foreach (rows[i]) begin
      txn(1'b0, rows[i].addr, 8'h00);
      chk(sfr_rdata_out, 8'h00);
      txn(1'b1, rows[i].addr, rows[i].data);
      txn(1'b0, rows[i].addr, 8'h00);
      chk(sfr_rdata_out, rows[i].want);
    end
    idle();
    int_enable_in = 1'b1;
    idle();
    chk({7'h00, timer_irq_out}, 8'h01);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h00);
    idle();
    chk({7'h00, timer_irq_out}, 8'h00);
    txn(1'b1, CRBT_ADDR_CAP_LO, 8'h34);
    txn(1'b1, CRBT_ADDR_CAP_HI, 8'h12);
    txn(1'b1, CRBT_ADDR_CNT_LO, 8'hfe);
    txn(1'b1, CRBT_ADDR_CNT_HI, 8'hff);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h04);
    idle();
    wait_pulse(0);
    chk({7'h00, conv_start_out}, 8'h01);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h80);
    chk({7'h00, conv_start_out}, 8'h00);
    txn(1'b0, CRBT_ADDR_CNT_LO, 8'h00);
    chk(sfr_rdata_out, 8'h35);
    txn(1'b0, CRBT_ADDR_CNT_HI, 8'h00);
    chk(sfr_rdata_out, 8'h12);
    txn(1'b0, CRBT_ADDR_CTRL, 8'h00);
    chk(sfr_rdata_out, 8'h80);
    chk({7'h00, timer_irq_out}, 8'h01);
    txn(1'b1, CRBT_ADDR_CAP_LO, 8'hff);
    txn(1'b1, CRBT_ADDR_CAP_HI, 8'hff);
    txn(1'b1, CRBT_ADDR_CNT_LO, 8'hff);
    txn(1'b1, CRBT_ADDR_CNT_HI, 8'hff);
    prescale_select_in = 1'b0;
    txn(1'b1, CRBT_ADDR_CTRL, 8'h04);
    idle();
    gap(0);
    chk(8'(n), 8'd12);
    prescale_select_in = 1'b1;
    gap(0);
    chk(8'(n), 8'd1);
    // Counter still ticks once at the edge that selects the pin
    txn(1'b1, CRBT_ADDR_CNT_LO, 8'h20);
    txn(1'b1, CRBT_ADDR_CNT_HI, 8'h43);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h07);
    idle();
    repeat (3) u_crbt_far_model.fall(1'b0);
    u_crbt_far_model.fall(1'b1);
    txn(1'b0, CRBT_ADDR_CTRL, 8'h00);
    chk(sfr_rdata_out, 8'h07);
    txn(1'b0, CRBT_ADDR_CAP_LO, 8'h00);
    chk(sfr_rdata_out, 8'hff);
    txn(1'b0, CRBT_ADDR_CNT_LO, 8'h00);
    chk(sfr_rdata_out, 8'h24);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h0f);
    idle();
    u_crbt_far_model.fall(1'b1);
    txn(1'b0, CRBT_ADDR_CAP_LO, 8'h00);
    chk(sfr_rdata_out, 8'h24);
    txn(1'b0, CRBT_ADDR_CAP_HI, 8'h00);
    chk(sfr_rdata_out, 8'h43);
    txn(1'b0, CRBT_ADDR_CTRL, 8'h00);
    chk(sfr_rdata_out, 8'h4f);
    chk({7'h00, timer_irq_out}, 8'h01);
    txn(1'b1, CRBT_ADDR_CNT_LO, 8'h00);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h0e);
    idle();
    u_crbt_far_model.fall(1'b1);
    txn(1'b0, CRBT_ADDR_CNT_LO, 8'h00);
    chk(sfr_rdata_out, 8'h24);
    txn(1'b0, CRBT_ADDR_CTRL, 8'h00);
    chk(sfr_rdata_out, 8'h4e);
    txn(1'b1, CRBT_ADDR_CAP_LO, 8'hfc);
    txn(1'b1, CRBT_ADDR_CAP_HI, 8'hff);
    txn(1'b1, CRBT_ADDR_CNT_LO, 8'hff);
    txn(1'b1, CRBT_ADDR_CNT_HI, 8'hff);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h3d);
    idle();
    gap(1);
    chk(8'(n), 8'd8);
    chk({7'h00, tx_baud_clk_out}, 8'h01);
    u_crbt_far_model.fall(1'b1);
    txn(1'b0, CRBT_ADDR_CTRL, 8'h00);
    chk(sfr_rdata_out, 8'h7d);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h20);
    txn(1'b0, CRBT_ADDR_CNT_LO, 8'h00);
    n = int'(sfr_rdata_out);
    idle();
    r0 = u_crbt_far_model.rx_seen;
    t0 = u_crbt_far_model.tx_seen;
    u_crbt_far_model.other();
    repeat (2) @(posedge clock_in);
    #1;
    chk(8'(u_crbt_far_model.rx_seen - r0), 8'h00);
    chk(8'(u_crbt_far_model.tx_seen - t0), 8'h01);
    txn(1'b0, CRBT_ADDR_CNT_LO, 8'h00);
    chk(sfr_rdata_out, 8'(n));
    // Baud mode fed from the pin: one overflow from all ones, then reload and one step
    txn(1'b1, CRBT_ADDR_CNT_LO, 8'hff);
    txn(1'b1, CRBT_ADDR_CNT_HI, 8'hff);
    txn(1'b1, CRBT_ADDR_CTRL, 8'h16);
    idle();
    t0 = u_crbt_far_model.tx_seen;
    repeat (2) u_crbt_far_model.fall(1'b0);
    chk(8'(u_crbt_far_model.tx_seen - t0), 8'h01);
    txn(1'b0, CRBT_ADDR_CNT_LO, 8'h00);
    chk(sfr_rdata_out, 8'hfd);
    rst_n_in = 1'b0;
    @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    txn(1'b0, CRBT_ADDR_CTRL, 8'h00);
    chk(sfr_rdata_out, 8'h00);
    idle();
    complete_run();
  end
endmodule : crbt_timer_tb
